// ===== sdr_host.sv
/*
  Bus master model standing in for software and DMA: single-word AHB-Lite cycles.
  Assumes one slave whose ready output is the bus ready.
*/
module sdr_host (
  input wire logic clk_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  output logic hsel_out,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // Bus cycle
  // ********
  initial
  begin
    hsel_out = 1'b0;
    haddr_out = 32'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h2;
    hwdata_out = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel_out <= 1'b1;
    haddr_out <= {20'h0, a};
    htrans_out <= 2'h2;
    hwrite_out <= w;
    @(posedge clk_in);
    while (hready_in !== 1'b1)
      @(posedge clk_in);
    hsel_out <= 1'b0;
    htrans_out <= 2'h0;
    hwdata_out <= d;
    @(posedge clk_in);
    while (hready_in !== 1'b1)
      @(posedge clk_in);
    q = hrdata_in;
  endtask
endmodule // sdr_host

// ===== sdr_pkg.sv
/*
  Package for the sensor decoder and result buffer: register map, field
  positions, reset values, timing constants, carrier and state types.
  Assumes a 10 MHz system clock and AHB-Lite word access to the registers.
*/
package sdr_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned SYS_CLK_HZ = 10_000_000;
  localparam int unsigned LF_CLK_HZ = 32_768;
  localparam int unsigned LF_DIV = SYS_CLK_HZ / LF_CLK_HZ;
  localparam int unsigned EVAL_LF_CYCLES = 2;

  // ****************************************
  // Sizes and buffer levels
  // ****************************************
  localparam int unsigned NUM_CH = 16;
  localparam int unsigned DEC_STATES = 16;
  localparam int unsigned DEC_INPUTS = 4;
  localparam int unsigned BUF_DEPTH = 16;
  localparam logic [4:0] HALF_LEVEL = 5'h08;
  localparam logic [4:0] FULL_LEVEL = 5'h10;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_DEC_CONTROL = 12'h004;
  localparam logic [11:0] OFS_DEC_STATE = 12'h008;
  localparam logic [11:0] OFS_DEC_INPUT = 12'h00c;
  localparam logic [11:0] OFS_FLAGS = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_SCAN_RESULT = 12'h018;
  localparam logic [11:0] OFS_POP = 12'h01c;
  localparam logic [11:0] OFS_DAC_DATA = 12'h020;
  localparam logic [11:0] OFS_CH_CFG = 12'h040;
  localparam logic [11:0] OFS_DESC_A = 12'h080;
  localparam logic [11:0] OFS_DESC_B = 12'h0c0;
  localparam logic [11:0] OFS_BUF_ENTRY = 12'h100;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned CTRL_OVERWRITE = 0;
  localparam int unsigned CTRL_LEVEL_SEL = 1;
  localparam int unsigned CTRL_STORE_SCAN = 2;
  localparam int unsigned CTRL_ERR_CHECK = 3;
  localparam int unsigned CTRL_BIAS_LSB = 4;
  localparam int unsigned CTRL_DSEL0 = 6;
  localparam int unsigned CTRL_DSEL1 = 7;
  localparam int unsigned CTRL_PRESC_LSB = 8;
  localparam int unsigned DC_COUNT_MODE = 0;
  localparam int unsigned DC_MAP = 1;
  localparam int unsigned DC_HYST_LSB = 2;
  localparam int unsigned DC_HYST_IRQ = 5;
  localparam int unsigned DS_TGT_LSB = 0;
  localparam int unsigned DS_MATCH_LSB = 4;
  localparam int unsigned DS_MASK_LSB = 8;
  localparam int unsigned DS_ACT_LSB = 12;
  localparam int unsigned DS_SET_FLAG = 15;
  localparam int unsigned DS_CHAIN = 16;
  localparam int unsigned CC_THR_LSB = 0;
  localparam int unsigned CC_ATH_LSB = 16;
  localparam int unsigned CC_DECODE = 28;
  localparam int unsigned CC_STORE = 29;
  localparam int unsigned CC_COUNTER = 30;
  localparam int unsigned CC_LESS = 31;
  localparam int unsigned FL_DEC = 16;
  localparam int unsigned FL_ERR = 17;
  localparam int unsigned FL_DV = 18;
  localparam int unsigned FL_LVL = 19;
  localparam int unsigned FL_OF = 20;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] CTRL_RST = 32'h0000_0100;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    BIAS_DUTY_CYCLED = 2'h0,
    BIAS_ALWAYS_ACCURATE = 2'h1,
    BIAS_NO_CONTROL = 2'h2
  } sdr_bias_t;

  typedef enum logic [1:0] {
    DEC_IDLE = 2'h0,
    DEC_EVAL_A = 2'h1,
    DEC_EVAL_B = 2'h3
  } sdr_dec_t;

  typedef struct packed {
    logic done;
    logic [3:0] ch;
    logic [15:0] count;
    logic cmp;
  } sdr_meas_t;

  typedef struct packed {
    logic refresh;
    logic [11:0] ch0;
    logic [11:0] ch1;
  } sdr_dac_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] decoder_control;
    logic [31:0] dacdata;
    logic [15:0][31:0] chcfg;
    logic [15:0][31:0] desc_a;
    logic [15:0][31:0] desc_b;
    logic [15:0][15:0] rbuf;
    logic [3:0] wr;
    logic [3:0] rd;
    logic [4:0] cnt;
    logic [3:0] dstate;
    logic [3:0] dvec;
    logic [1:0] dpos;
    logic [3:0] snap;
    logic [3:0] prev_vec;
    sdr_dec_t dfsm;
    logic [3:0] pair;
    logic chained;
    logic last_b;
    logic last_ok;
    logic dir;
    logic [2:0] ev;
    logic [20:0] flags;
    logic [15:0] scan_work;
    logic [15:0] scan_res;
    logic [15:0] lfcnt;
    logic lf_tick;
    logic [7:0] dcnt;
    logic dac_tick;
    sdr_dac_t dac;
    logic [5:0] scale;
    logic [3:0] mux;
    logic bias_hi;
    logic bias_en;
    logic dma_req;
    logic dma_sreq;
    logic wpend;
    logic [11:0] waddr;
    logic [31:0] hrdata;
    logic hreadyout;
  } sdr_state_t;

endpackage

// ===== sdr_top.sv
/*
  Post-scan logic: state-machine decoder, circular result buffer, DAC
  refresh, comparator control, bias control and DMA requests.
  Assumes measurement strobes synchronous to CLK_SYS_IN, AUX_TICK_IN a
  one-cycle enable from the auxiliary oscillator, and one AHB-Lite master.
*/
// Chosen here: the AHB-Lite register port and the placing of the registers.
// How it works
// - Decoder is a 16-state programmable machine fed by four sensor bits.
// - Decode-enabled channels fill the input vector; evaluation waits for scan end.
// - Unmasked bits compared against descriptor A and B; match moves to target state.
// - Each transition pulses the event channels named by the descriptor action.
// - Count mode: channel 0 pulses per count, channel 1 holds direction.
// - Flag-set bit raises decoder flag; mapping also raises the source state's flag.
// - Chain bit with no match moves evaluation to the next descriptor pair.
// - Each descriptor pair takes two low-frequency clock cycles.
// - Error check: no match yet changed input raises the decoder error flag.
// - A after B or B after A triggers hysteresis; a chained jump cancels it.
// - Hysteresis masks chosen event channels and flags; error flag never masked.
// - Sixteen-entry ring; write pointer advances per write, read per pop if data.
// - Full buffer drops writes unless popped that cycle or overwrite, which drags the read pointer along.
// - Data-valid, half-full, full status; level flag per select; overflow flag.
// - Scan result bit is comparator output or threshold compare of the count.
// - Store-enabled samples go in during scan; result vector after scan if enabled.
// - Indexed entry reads leave pointers and status untouched.
// - Both DAC channels refreshed per measurement from data register or threshold.
// - Supply scale from six threshold bits; comparator mux follows active channel.
// - Bias accurate while active in duty mode, always in accurate, untouched in none.
// - DMA request tracks the selected level; single request while data unread.
module sdr_top #(
  parameter int unsigned LF_DIV = sdr_pkg::LF_DIV
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire sdr_pkg::sdr_meas_t MEAS_IN,
  input wire logic SCAN_DONE_IN,
  input wire logic MEAS_START_IN,
  input wire logic [3:0] ACTIVE_CH_IN,
  input wire logic SENSOR_ACTIVE_IN,
  input wire logic AUX_TICK_IN,
  output logic [2:0] EVENT_OUT,
  output sdr_pkg::sdr_dac_t DAC_OUT,
  output logic DAC_CLK_EN_OUT,
  output logic [5:0] SUPPLY_SCALE_OUT,
  output logic [3:0] CMP_MUX_OUT,
  output logic BIAS_HIGH_ACC_OUT,
  output logic BIAS_CTRL_EN_OUT,
  output logic DMA_REQ_OUT,
  output logic DMA_SREQ_OUT
);

  // ****************************************
  // Parameter check and helpers
  // ****************************************
  if (LF_DIV < 2 || LF_DIV > 65536)
  begin : g_bad_div
    $error("LF_DIV out of range");
  end

  function automatic logic in_region(input logic [11:0] a, input logic [11:0] base);
    return a[11:6] == base[11:6];
  endfunction

  function automatic logic [31:0] rd_word(input sdr_pkg::sdr_state_t st,
                                          input logic [11:0] a);
    logic [31:0] w;
    w = 32'h0;
    if (in_region(a, sdr_pkg::OFS_CH_CFG))
      w = st.chcfg[a[5:2]];
    else if (in_region(a, sdr_pkg::OFS_DESC_A))
      w = st.desc_a[a[5:2]];
    else if (in_region(a, sdr_pkg::OFS_DESC_B))
      w = st.desc_b[a[5:2]];
    else if (in_region(a, sdr_pkg::OFS_BUF_ENTRY))
      w = {16'h0, st.rbuf[a[5:2]]};
    else
    begin
      case (a)
        sdr_pkg::OFS_CTRL: w = st.ctrl;
        sdr_pkg::OFS_DEC_CONTROL: w = st.decoder_control;
        sdr_pkg::OFS_DEC_STATE: w = {28'h0, st.dstate};
        sdr_pkg::OFS_DEC_INPUT: w = {28'h0, st.dvec};
        sdr_pkg::OFS_FLAGS: w = {11'h0, st.flags};
        sdr_pkg::OFS_STATUS: w = {16'h0, 3'h0, st.cnt, st.rd, st.wr} << 8 |
          {29'h0, st.cnt == sdr_pkg::FULL_LEVEL, st.cnt >= sdr_pkg::HALF_LEVEL,
          st.cnt != 5'h00};
        sdr_pkg::OFS_SCAN_RESULT: w = {16'h0, st.scan_res};
        sdr_pkg::OFS_POP: w = (st.cnt != 5'h00) ? {16'h0, st.rbuf[st.rd]} : 32'h0;
        sdr_pkg::OFS_DAC_DATA: w = st.dacdata;
        default: w = 32'h0;
      endcase
    end
    return w;
  endfunction

  // ****************************************
  // State and next state
  // ****************************************
  sdr_pkg::sdr_state_t s;
  sdr_pkg::sdr_state_t n;
  logic addr_ok;
  logic pop;
  logic can_pop;
  logic push;
  logic wrote;
  logic full_now;
  logic inc;
  logic lvl;
  logic trig;
  logic ma;
  logic mb;
  logic trans_hit;
  logic hyst_hit;
  logic err_hit;
  logic [2:0] act;
  logic [2:0] supp;
  logic [15:0] pdata;
  logic [20:0] fset;
  logic [20:0] fclr;
  logic [31:0] cfg;
  logic [31:0] da;
  logic [31:0] db;
  logic [31:0] d;

  always_comb
  begin
    n = s;
    n.ev = 3'h0;
    n.lf_tick = 1'b0;
    n.dac_tick = 1'b0;
    n.dac.refresh = 1'b0;
    push = 1'b0;
    pdata = 16'h0;
    fset = 21'h0;
    fclr = 21'h0;
    trig = 1'b0;
    trans_hit = 1'b0;
    hyst_hit = 1'b0;
    err_hit = 1'b0;
    act = 3'h0;
    supp = 3'h0;
    cfg = s.chcfg[MEAS_IN.ch];
    da = s.desc_a[s.pair];
    db = s.desc_b[s.pair];
    ma = ((s.snap ^ da[sdr_pkg::DS_MATCH_LSB +: 4]) & ~da[sdr_pkg::DS_MASK_LSB +: 4]) == 4'h0;
    mb = ((s.snap ^ db[sdr_pkg::DS_MATCH_LSB +: 4]) & ~db[sdr_pkg::DS_MASK_LSB +: 4]) == 4'h0;
    d = ma ? da : db;
    // Low-frequency sensor clock enable
    if (s.lfcnt == 16'(LF_DIV - 1))
    begin
      n.lfcnt = 16'h0;
      n.lf_tick = 1'b1;
    end
    else
      n.lfcnt = s.lfcnt + 16'h1;
    // Bus slave: address phase and deferred write data phase
    addr_ok = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    pop = addr_ok && !HWRITE_IN && HADDR_IN[11:0] == sdr_pkg::OFS_POP;
    n.hrdata = (addr_ok && !HWRITE_IN) ? rd_word(s, HADDR_IN[11:0]) : 32'h0;
    n.wpend = addr_ok && HWRITE_IN;
    n.waddr = HADDR_IN[11:0];
    n.hreadyout = 1'b1;
    if (s.wpend)
    begin
      if (in_region(s.waddr, sdr_pkg::OFS_CH_CFG))
        n.chcfg[s.waddr[5:2]] = HWDATA_IN;
      else if (in_region(s.waddr, sdr_pkg::OFS_DESC_A))
        n.desc_a[s.waddr[5:2]] = HWDATA_IN;
      else if (in_region(s.waddr, sdr_pkg::OFS_DESC_B))
        n.desc_b[s.waddr[5:2]] = HWDATA_IN;
      else
      begin
        case (s.waddr)
          sdr_pkg::OFS_CTRL: n.ctrl = HWDATA_IN;
          sdr_pkg::OFS_DEC_CONTROL: n.decoder_control = HWDATA_IN;
          sdr_pkg::OFS_DEC_STATE: n.dstate = HWDATA_IN[3:0];
          sdr_pkg::OFS_FLAGS: fclr = HWDATA_IN[20:0];
          sdr_pkg::OFS_DAC_DATA: n.dacdata = HWDATA_IN;
          default: n.dacdata = s.dacdata;
        endcase
      end
    end
    // Channel results during a scan
    if (MEAS_IN.done)
    begin
      if (cfg[sdr_pkg::CC_COUNTER])
        trig = cfg[sdr_pkg::CC_LESS] ? (MEAS_IN.count < cfg[sdr_pkg::CC_THR_LSB +: 16]) :
          (MEAS_IN.count >= cfg[sdr_pkg::CC_THR_LSB +: 16]);
      else
        trig = MEAS_IN.cmp;
      n.scan_work[MEAS_IN.ch] = trig;
      if (cfg[sdr_pkg::CC_DECODE])
      begin
        n.dvec[s.dpos] = trig;
        n.dpos = (s.dpos == 2'h3) ? s.dpos : s.dpos + 2'h1;
      end
      if (cfg[sdr_pkg::CC_STORE])
      begin
        push = 1'b1;
        pdata = cfg[sdr_pkg::CC_COUNTER] ? MEAS_IN.count : {15'h0, MEAS_IN.cmp};
      end
    end
    else if (SCAN_DONE_IN)
    begin
      n.scan_res = s.scan_work;
      n.scan_work = 16'h0;
      n.dpos = 2'h0;
      if (s.ctrl[sdr_pkg::CTRL_STORE_SCAN])
      begin
        push = 1'b1;
        pdata = s.scan_work;
      end
      if (s.dfsm == sdr_pkg::DEC_IDLE)
      begin
        n.snap = s.dvec;
        n.pair = s.dstate;
        n.chained = 1'b0;
        n.dfsm = sdr_pkg::DEC_EVAL_A;
      end
    end
    // ****************************************
    // Decoder
    // ****************************************
    case (s.dfsm)
      sdr_pkg::DEC_IDLE: n.chained = n.chained;
      sdr_pkg::DEC_EVAL_A:
        if (s.lf_tick)
          n.dfsm = sdr_pkg::DEC_EVAL_B;
      sdr_pkg::DEC_EVAL_B:
        if (s.lf_tick)
        begin
          if (ma || mb)
          begin
            trans_hit = 1'b1;
            hyst_hit = s.last_ok && (s.last_b != !ma) && !s.chained;
            n.last_b = !ma;
            n.last_ok = 1'b1;
            n.dstate = d[sdr_pkg::DS_TGT_LSB +: 4];
            supp = hyst_hit ? s.decoder_control[sdr_pkg::DC_HYST_LSB +: 3] : 3'h0;
            act = d[sdr_pkg::DS_ACT_LSB +: 3] & ~supp;
            if (s.decoder_control[sdr_pkg::DC_COUNT_MODE])
            begin
              n.ev[0] = act[0];
              n.ev[2] = act[2];
              if (act[0])
                n.dir = act[1];
            end
            else
              n.ev = act;
            if (d[sdr_pkg::DS_SET_FLAG] && !(hyst_hit && s.decoder_control[sdr_pkg::DC_HYST_IRQ]))
            begin
              fset[sdr_pkg::FL_DEC] = 1'b1;
              if (s.decoder_control[sdr_pkg::DC_MAP])
                fset[s.dstate] = 1'b1;
            end
            n.prev_vec = s.snap;
            n.dfsm = sdr_pkg::DEC_IDLE;
          end
          else if (da[sdr_pkg::DS_CHAIN] && s.pair != 4'hf)
          begin
            n.pair = s.pair + 4'h1;
            n.chained = 1'b1;
            n.dfsm = sdr_pkg::DEC_EVAL_A;
          end
          else
          begin
            err_hit = s.ctrl[sdr_pkg::CTRL_ERR_CHECK] && s.snap != s.prev_vec;
            fset[sdr_pkg::FL_ERR] = err_hit;
            n.prev_vec = s.snap;
            n.dfsm = sdr_pkg::DEC_IDLE;
          end
        end
      default: n.dfsm = sdr_pkg::DEC_IDLE;
    endcase
    if (s.decoder_control[sdr_pkg::DC_COUNT_MODE])
      n.ev[1] = n.dir;
    // ****************************************
    // Result buffer
    // ****************************************
    can_pop = pop && s.cnt != 5'h00;
    full_now = s.cnt == sdr_pkg::FULL_LEVEL;
    wrote = push && (!full_now || can_pop || s.ctrl[sdr_pkg::CTRL_OVERWRITE]);
    if (wrote)
    begin
      n.rbuf[s.wr] = pdata;
      n.wr = s.wr + 4'h1;
    end
    if (push && full_now && !can_pop)
      fset[sdr_pkg::FL_OF] = 1'b1;
    inc = wrote && !(full_now && !can_pop);
    n.rd = s.rd + 4'(can_pop || (wrote && full_now && !can_pop));
    n.cnt = s.cnt + 5'(inc) - 5'(can_pop);
    lvl = s.ctrl[sdr_pkg::CTRL_LEVEL_SEL] ? (n.cnt == sdr_pkg::FULL_LEVEL) :
      (n.cnt >= sdr_pkg::HALF_LEVEL);
    fset[sdr_pkg::FL_DV] = wrote;
    fset[sdr_pkg::FL_LVL] = lvl;
    n.dma_req = lvl;
    n.dma_sreq = n.cnt != 5'h00;
    n.flags = (s.flags & ~fclr) | fset;
    // ****************************************
    // DAC, comparator and bias control
    // ****************************************
    if (AUX_TICK_IN)
    begin
      if (s.dcnt >= s.ctrl[sdr_pkg::CTRL_PRESC_LSB +: 8])
      begin
        n.dcnt = 8'h0;
        n.dac_tick = 1'b1;
      end
      else
        n.dcnt = s.dcnt + 8'h1;
    end
    if (MEAS_START_IN)
    begin
      n.dac.refresh = 1'b1;
      n.dac.ch0 = s.ctrl[sdr_pkg::CTRL_DSEL0] ? s.chcfg[ACTIVE_CH_IN][sdr_pkg::CC_ATH_LSB +: 12] :
        s.dacdata[11:0];
      n.dac.ch1 = s.ctrl[sdr_pkg::CTRL_DSEL1] ? s.chcfg[ACTIVE_CH_IN][sdr_pkg::CC_ATH_LSB +: 12] :
        s.dacdata[27:16];
    end
    n.scale = s.chcfg[ACTIVE_CH_IN][sdr_pkg::CC_ATH_LSB +: 6];
    n.mux = ACTIVE_CH_IN;
    case (s.ctrl[sdr_pkg::CTRL_BIAS_LSB +: 2])
      sdr_pkg::BIAS_DUTY_CYCLED:
      begin
        n.bias_en = 1'b1;
        n.bias_hi = SENSOR_ACTIVE_IN;
      end
      sdr_pkg::BIAS_ALWAYS_ACCURATE:
      begin
        n.bias_en = 1'b1;
        n.bias_hi = 1'b1;
      end
      default: n.bias_en = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      s <= '0;
      s.ctrl <= sdr_pkg::CTRL_RST;
      s.hreadyout <= 1'b1;
    end
    else
      s <= n;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign HRDATA_OUT = s.hrdata;
  assign HREADYOUT_OUT = s.hreadyout;
  assign HRESP_OUT = 1'b0;
  assign EVENT_OUT = s.ev;
  assign DAC_OUT = s.dac;
  assign DAC_CLK_EN_OUT = s.dac_tick;
  assign SUPPLY_SCALE_OUT = s.scale;
  assign CMP_MUX_OUT = s.mux;
  assign BIAS_HIGH_ACC_OUT = s.bias_hi;
  assign BIAS_CTRL_EN_OUT = s.bias_en;
  assign DMA_REQ_OUT = s.dma_req;
  assign DMA_SREQ_OUT = s.dma_sreq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (RST_IN);

  property p_eval_two_ticks;
    (s.dfsm == sdr_pkg::DEC_EVAL_A && s.lf_tick) |=> s.dfsm == sdr_pkg::DEC_EVAL_B;
  endproperty
  a_eval_two_ticks: assert property (p_eval_two_ticks) else $error("pair eval skipped");

  property p_pop_advance;
    (can_pop && !wrote) |=> (s.rd == $past(s.rd) + 4'h1) && (s.cnt == $past(s.cnt) - 5'h1);
  endproperty
  a_pop_advance: assert property (p_pop_advance) else $error("pop did not advance");

  property p_empty_hold;
    (pop && s.cnt == 5'h00 && !push) |=> (s.rd == $past(s.rd)) && s.cnt == 5'h00;
  endproperty
  a_empty_hold: assert property (p_empty_hold) else $error("empty pop moved pointer");

  property p_full_drop;
    (push && full_now && !s.ctrl[sdr_pkg::CTRL_OVERWRITE] && !pop)
      |=> (s.wr == $past(s.wr)) && s.flags[sdr_pkg::FL_OF];
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("write into full buffer");

  property p_overwrite_follow;
    (push && full_now && s.ctrl[sdr_pkg::CTRL_OVERWRITE] && !pop)
      |=> (s.rd == $past(s.rd) + 4'h1) && (s.wr == $past(s.wr) + 4'h1);
  endproperty
  a_overwrite_follow: assert property (p_overwrite_follow) else $error("read ptr lagged");

  property p_level_dma;
    (s.cnt >= sdr_pkg::HALF_LEVEL && !$past(s.ctrl[sdr_pkg::CTRL_LEVEL_SEL])) |-> DMA_REQ_OUT;
  endproperty
  a_level_dma: assert property (p_level_dma) else $error("level request missing");

  property p_single_dma;
    (s.cnt != 5'h00) |-> DMA_SREQ_OUT;
  endproperty
  a_single_dma: assert property (p_single_dma) else $error("single request missing");

  property p_err_flag;
    err_hit |=> s.flags[sdr_pkg::FL_ERR];
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag not set");

  property p_event_pulse;
    (trans_hit && act[2]) |=> EVENT_OUT[2] ##1 !EVENT_OUT[2];
  endproperty
  a_event_pulse: assert property (p_event_pulse) else $error("event pulse wrong");

  property p_peek_no_pop;
    (addr_ok && !HWRITE_IN && in_region(HADDR_IN[11:0], sdr_pkg::OFS_BUF_ENTRY) && !push)
      |=> s.rd == $past(s.rd);
  endproperty
  a_peek_no_pop: assert property (p_peek_no_pop) else $error("peek moved read ptr");

  c_transition: cover property (trans_hit);
  c_hysteresis: cover property (hyst_hit);
  c_chain: cover property (s.dfsm == sdr_pkg::DEC_EVAL_B && s.lf_tick && !ma && !mb &&
    da[sdr_pkg::DS_CHAIN]);
  c_overflow: cover property ($rose(s.flags[sdr_pkg::FL_OF]));

endmodule // sdr_top

// ===== tb.sv
/*
  Self-checking bench for sdr_top: registers, result buffer, decoder, bias.
  Assumes sdr_host as bus master and LF_DIV shortened to 4.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // Signals
  // ********
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scan = 1'b0;
  logic aux = 1'b0;
  sdr_pkg::sdr_meas_t meas_in = '0;
  logic hsel, hwrite, hready;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [2:0] ev;
  logic dma, sreq, bias_hi, bias_en;
  logic mstart = 1'b0;
  logic sact = 1'b0;
  logic [3:0] ach = 4'h0;
  logic dclk;
  logic [5:0] scale;
  logic [3:0] mux;
  sdr_pkg::sdr_dac_t dac;
  int n_fail = 0;
  int num_checks = 0;
  always #50 clk = ~clk;
  always @(posedge clk) aux <= ~aux;
  sdr_top #(.LF_DIV(4)) i_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(), .MEAS_IN(meas_in), .SCAN_DONE_IN(scan),
    .MEAS_START_IN(mstart), .ACTIVE_CH_IN(ach), .SENSOR_ACTIVE_IN(sact),
    .AUX_TICK_IN(aux), .EVENT_OUT(ev), .DAC_OUT(dac), .DAC_CLK_EN_OUT(dclk),
    .SUPPLY_SCALE_OUT(scale), .CMP_MUX_OUT(mux), .BIAS_HIGH_ACC_OUT(bias_hi),
    .BIAS_CTRL_EN_OUT(bias_en), .DMA_REQ_OUT(dma), .DMA_SREQ_OUT(sreq));
  sdr_host i_host (.clk_in(clk), .hready_in(hready), .hrdata_in(hrdata),
    .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
    .hsize_out(hsize), .hwdata_out(hwdata));
  // ********
  // Helpers
  // ********
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    i_host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic meas(input logic [3:0] c, input logic [15:0] n, input logic k);
    meas_in <= {1'b1, c, n, k};
    @(posedge clk);
    meas_in <= '0;
    @(posedge clk);
  endtask
  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_regs();
    logic [31:0] q;
    rd(12'h000, q);
    chk("ctrl reset", 32'h0000_0100, q);
    rd(12'h200, q);
    chk("unmapped", 32'h0, q);
    wr(12'h000, 32'h0000_0110);
    rd(12'h000, q);
    chk("ctrl write", 32'h0000_0110, q);
    chk("bias accurate", 32'h3, {30'h0, bias_en, bias_hi});
  endtask
  task automatic t_buf();
    logic [31:0] q;
    wr(12'h040, 32'h6000_0000);
    for (int i = 0; i < 17; i++)
      meas(4'h0, 16'h0a00 + 16'(i), 1'b0);
    rd(12'h014, q);
    chk("status full", 32'h0010_0007, q);
    chk("dma level", 32'h3, {30'h0, dma, sreq});
    rd(12'h010, q);
    chk("overflow", 32'h0010_0000, q & 32'h0010_0000);
    rd(12'h10c, q);
    chk("entry 3", 32'h0000_0a03, q);
    rd(12'h01c, q);
    chk("pop", 32'h0000_0a00, q);
    rd(12'h014, q);
    chk("status pop", 32'h000f_1003, q);
    wr(12'h000, 32'h0000_0111);
    meas(4'h0, 16'h0b00, 1'b0);
    meas(4'h0, 16'h0b01, 1'b0);
    rd(12'h01c, q);
    chk("oldest", 32'h0000_0a02, q);
  endtask
  task automatic dec_scan(input logic k, output logic [2:0] seen);
    meas(4'h1, 16'h0, k);
    scan <= 1'b1;
    @(posedge clk);
    scan <= 1'b0;
    seen = 3'h0;
    repeat (60)
    begin
      @(posedge clk);
      seen = seen | ev;
    end
  endtask
  task automatic t_dec();
    logic [31:0] q;
    logic [2:0] seen;
    wr(12'h044, 32'h1000_0000);
    wr(12'h080, 32'h0000_9e11);
    wr(12'h0c0, 32'h0000_0e02);
    dec_scan(1'b1, seen);
    chk("events", 32'h1, {29'h0, seen});
    rd(12'h00c, q);
    chk("input vector", 32'h1, q);
    rd(12'h008, q);
    chk("state", 32'h1, q);
    rd(12'h010, q);
    chk("dec flag", 32'h0001_0000, q & 32'h0003_0000);
    wr(12'h084, 32'h0000_0e12);
    wr(12'h0c4, 32'h0000_9e00);
    wr(12'h004, 32'h0000_0024);
    wr(12'h010, 32'h0001_0000);
    dec_scan(1'b0, seen);
    chk("hyst events", 32'h0, {29'h0, seen});
    rd(12'h008, q);
    chk("state b", 32'h0, q);
    rd(12'h010, q);
    chk("hyst flag", 32'h0, q & 32'h0003_0000);
  endtask
  task automatic t_dac();
    int k;
    wr(12'h020, 32'h0456_0123);
    wr(12'h048, 32'h0abc_0000);
    wr(12'h000, 32'h0000_0181);
    ach <= 4'h2;
    sact <= 1'b1;
    mstart <= 1'b1;
    @(posedge clk);
    mstart <= 1'b0;
    @(posedge clk);
    chk("dac", 32'h0112_3abc, {7'h0, dac});
    chk("scale", 32'h0000_003c, {26'h0, scale});
    chk("mux", 32'h0000_0002, {28'h0, mux});
    chk("bias duty on", 32'h3, {30'h0, bias_en, bias_hi});
    sact <= 1'b0;
    k = 0;
    repeat (40)
    begin
      @(posedge clk);
      k += int'(dclk);
    end
    chk("bias duty off", 32'h2, {30'h0, bias_en, bias_hi});
    chk("dac clock", 32'h0000_000a, 32'(k));
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_buf();
    t_dec();
    t_dac();
    finish_test();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule // tb
